// *** rtl/coi_consts.vh ***
// constants shared by the identifier classifier design files
`ifndef COI_CONSTS_VH
`define COI_CONSTS_VH

// ****************************************************************
// identifier layout
// ****************************************************************
`define COI_ID_W        11
`define COI_FC_W        4
`define COI_ADDR_W      7
`define COI_FC_MSB      10
`define COI_FC_LSB      7
`define COI_ADDR_MSB    6
`define COI_ADDR_ZERO   7'h00
`define COI_ID_NMT      11'h000

// ****************************************************************
// function codes
// ****************************************************************
`define COI_FC_NMT      4'h0
`define COI_FC_SYNC     4'h1
`define COI_FC_EMCY     4'h1
`define COI_FC_TPDO1    4'h3
`define COI_FC_RPDO4    4'hA
`define COI_FC_SDOTX    4'hB
`define COI_FC_SDORX    4'hC
`define COI_FC_HBEAT    4'hE

// ****************************************************************
// identifier table slots
// ****************************************************************
`define COI_SLOTS       13
`define COI_SLOT_W      4
`define COI_SLOT_SYNC   4'h0
`define COI_SLOT_EMCY   4'h1
`define COI_SLOT_TPDO1  4'h2
`define COI_SLOT_RPDO4  4'h9
`define COI_SLOT_SDOTX  4'hA
`define COI_SLOT_SDORX  4'hB
`define COI_SLOT_HBEAT  4'hC
`define COI_SLOT_NONE   4'hF

// ****************************************************************
// frame classes
// ****************************************************************
`define COI_CLS_W       4
`define COI_CLS_NMT     4'h0
`define COI_CLS_SYNC    4'h1
`define COI_CLS_EMCY    4'h2
`define COI_CLS_TPDO    4'h3
`define COI_CLS_RPDO    4'h4
`define COI_CLS_SDOTX   4'h5
`define COI_CLS_SDORX   4'h6
`define COI_CLS_HBEAT   4'h7
`define COI_CLS_UNKNOWN 4'h8

// ****************************************************************
// node address limits and dictionary
// ****************************************************************
`define COI_NODE_W      8
`define COI_NODE_MIN    8'h01
`define COI_NODE_MAX    8'h7F
`define COI_IDX_W       16
`define COI_SUB_W       8
`define COI_IDX_DT_LO   16'h0001
`define COI_IDX_DT_HI   16'h025F
`define COI_IDX_CM_LO   16'h1000
`define COI_IDX_CM_HI   16'h1FFF
`define COI_IDX_MF_LO   16'h2000
`define COI_IDX_MF_HI   16'h5FFF
`define COI_IDX_SD_LO   16'h6000
`define COI_IDX_SD_HI   16'h9FFF
`define COI_RNG_W       3
`define COI_RNG_RSVD    3'h0
`define COI_RNG_DTYPE   3'h1
`define COI_RNG_COMM    3'h2
`define COI_RNG_MFR     3'h3
`define COI_RNG_STD     3'h4
`define COI_ACC_W       2
`define COI_ACC_RO      2'h0
`define COI_ACC_RW      2'h1
`define COI_ACC_CONST   2'h2
`define COI_CNT_W       16
`define COI_CNT_ONE     16'h0001

`endif

// *** rtl/coi_id_match.v ***
// one identifier slot: default or configured value, and receive compare
`timescale 1ns/1ps
`include "coi_consts.vh"

module coi_id_match #(
  parameter [`COI_FC_W-1:0] FC     = `COI_FC_NMT,
  parameter                 SHARED = 0
) (
  input  wire [`COI_ADDR_W-1:0] nodeAddr, // own node address
  input  wire [`COI_ID_W-1:0]   cfgId,    // configured identifier
  input  wire                   cfgOvr,   // configured value in use
  input  wire [`COI_ID_W-1:0]   rxId,     // identifier to compare
  output wire [`COI_ID_W-1:0]   effId,    // identifier in force
  output wire                   hit       // rxId equals effId
);

  wire [`COI_ID_W-1:0] baseId;
  wire [`COI_ID_W-1:0] addrExt;
  wire [`COI_ID_W-1:0] dfltId;

  assign baseId  = {FC, `COI_ADDR_ZERO};
  assign addrExt = {{`COI_FC_W{1'b0}}, nodeAddr};
  // shared objects carry no node address
  assign dfltId  = (SHARED != 0) ? baseId : (baseId + addrExt);
  assign effId   = cfgOvr ? cfgId : dfltId;
  assign hit     = (rxId == effId);

endmodule

// *** rtl/coi_index_class.v ***
// dictionary index range decode and write permission check
`timescale 1ns/1ps
`include "coi_consts.vh"

module coi_index_class (
  input  wire [`COI_IDX_W-1:0] index,   // dictionary index
  input  wire [`COI_ACC_W-1:0] access,  // entry access attribute
  input  wire                  isWrite, // request is a write
  output reg  [`COI_RNG_W-1:0] range,   // range class of the index
  output wire                  allowed  // access is permitted
);

  always @* begin
    range = `COI_RNG_RSVD;
    if (index >= `COI_IDX_DT_LO && index <= `COI_IDX_DT_HI) begin
      range = `COI_RNG_DTYPE;
    end else if (index >= `COI_IDX_CM_LO && index <= `COI_IDX_CM_HI) begin
      range = `COI_RNG_COMM;
    end else if (index >= `COI_IDX_MF_LO && index <= `COI_IDX_MF_HI) begin
      range = `COI_RNG_MFR;
    end else if (index >= `COI_IDX_SD_LO && index <= `COI_IDX_SD_HI) begin
      range = `COI_RNG_STD;
    end
  end

  // reads always pass; only read-write entries take a write
  assign allowed = !isWrite || (access == `COI_ACC_RW);

endmodule

// *** rtl/coi_classifier.v ***
// identifier classification, generation and dictionary index checks
`timescale 1ns/1ps
`include "coi_consts.vh"

// Notes on behaviour
// - identifiers are eleven bits, taken from the standard frame id field.
// - bits 10..7 hold the function code, bits 6..0 the node address.
// - management uses id 0, sync uses 80h; both carry no address.
// - other defaults are function code in bits 10..7 plus node address.
// - emergency frames use function code 0001 plus address, 81h..FFh.
// - first transmit data object uses function code 0011, 181h..1FFh.
// - first receive data object accepted under 0100, 201h..27Fh.
// - second transmit data object uses 0101, 281h..2FFh.
// - second receive data object accepted under 0110, 301h..37Fh.
// - third transmit data object uses 0111, 381h..3FFh.
// - third receive data object accepted under 1000, 401h..47Fh.
// - fourth transmit data object uses 1001, 481h..4FFh.
// - fourth receive data object accepted under 1010, 501h..57Fh.
// - service-data responses use 1011, 581h..5FFh.
// - service-data requests arrive under 1100, 601h..67Fh.
// - guarding and heartbeat frames use 1110, 701h..77Fh.
// - identifiers written during configuration replace defaults until restored or reset.
// - each dictionary entry is selected by a sixteen-bit index.
// - index ranges: data types, communication, maker, device, reserved.
// - entries are ro, rw or const; only rw entries accept writes.
// - array and record entries also need a sub-index.
// - exactly four receive and four transmit data objects exist.
module coi_classifier (
  input  wire                    clock,       // 20 MHz system clock
  input  wire                    rst,         // synchronous reset, high
  input  wire [`COI_NODE_W-1:0]  nodeAddr,    // configured node address
  input  wire                    cfgMode,     // configuration phase
  input  wire                    cfgWrite,    // write one identifier slot
  input  wire                    cfgRestore,  // return slot to default
  input  wire [`COI_SLOT_W-1:0]  cfgSel,      // slot to write or read
  input  wire [`COI_ID_W-1:0]    cfgId,       // identifier to store
  input  wire                    rxValid,     // received frame strobe
  input  wire [`COI_ID_W-1:0]    rxId,        // received identifier
  input  wire                    txReq,       // identifier request
  input  wire [`COI_SLOT_W-1:0]  txSel,       // slot whose id is wanted
  input  wire                    dictReq,     // dictionary access check
  input  wire [`COI_IDX_W-1:0]   dictIndex,   // entry index
  input  wire [`COI_SUB_W-1:0]   dictSub,     // entry sub-index
  input  wire [`COI_ACC_W-1:0]   dictAccess,  // entry access attribute
  input  wire                    dictWrite,   // access is a write
  output reg                     addrBad,     // node address invalid
  output reg  [`COI_ID_W-1:0]    cfgRdId,     // identifier of cfgSel
  output reg                     cfgRdOvr,    // cfgSel holds configured id
  output reg                     rxDone,      // classification pulse
  output reg  [`COI_CLS_W-1:0]   rxClass,     // frame class
  output reg  [1:0]              rxPdo,       // data object number - 1
  output reg  [`COI_SLOT_W-1:0]  rxSlot,      // matched slot or none
  output reg                     rxOwn,       // frame is for this node
  output reg  [`COI_CNT_W-1:0]   rxOwnCnt,    // frames accepted
  output reg  [`COI_CNT_W-1:0]   rxOtherCnt,  // frames passed over
  output reg                     txDone,      // identifier answer pulse
  output reg  [`COI_ID_W-1:0]    txId,        // identifier to send with
  output reg                     txOk,        // answer usable
  output reg                     dictDone,    // dictionary answer pulse
  output reg  [`COI_RNG_W-1:0]   dictRange,   // index range class
  output reg                     dictAllowed, // access permitted
  output reg  [`COI_IDX_W+`COI_SUB_W-1:0] dictKey // index and sub-index
);

  // ****************************************************************
  // slot helpers
  // ****************************************************************
  // slots 2..11 are laid out so that the function code is slot + 1
  function [`COI_FC_W-1:0] slotFc;
    input integer s;

    begin
      if (s == `COI_SLOT_SYNC) begin
        slotFc = `COI_FC_SYNC;
      end else if (s == `COI_SLOT_EMCY) begin
        slotFc = `COI_FC_EMCY;
      end else if (s == `COI_SLOT_HBEAT) begin
        slotFc = `COI_FC_HBEAT;
      end else begin
        slotFc = s[`COI_FC_W-1:0] + `COI_FC_SYNC;
      end
    end
  endfunction

  // fallback class for frames no slot claims
  function [`COI_CLS_W-1:0] fcClass;
    input [`COI_FC_W-1:0] fc;
    input                 addrZero;

    begin
      case (fc)
        `COI_FC_NMT:   fcClass = `COI_CLS_NMT;
        `COI_FC_SYNC:  fcClass = addrZero ? `COI_CLS_SYNC : `COI_CLS_EMCY;
        `COI_FC_SDOTX: fcClass = `COI_CLS_SDOTX;
        `COI_FC_SDORX: fcClass = `COI_CLS_SDORX;
        `COI_FC_HBEAT: fcClass = `COI_CLS_HBEAT;

        default: begin
          if (fc >= `COI_FC_TPDO1 && fc <= `COI_FC_RPDO4) begin
            // odd codes transmit, even codes receive (node view)
            fcClass = fc[0] ? `COI_CLS_TPDO : `COI_CLS_RPDO;
          end else begin
            fcClass = `COI_CLS_UNKNOWN;
          end
        end
      endcase
    end
  endfunction

  // SYNC, receive objects and SDO rx
  function slotIsRx;
    input integer s;
    begin
      slotIsRx = (s == `COI_SLOT_SYNC) || (s == `COI_SLOT_SDORX) ||
                 (s >= `COI_SLOT_TPDO1 && s <= `COI_SLOT_RPDO4 &&
                  s[0] == 1'b1);
    end
  endfunction

  // ****************************************************************
  // node address check
  // ****************************************************************
  wire                   addrOk;
  wire [`COI_ADDR_W-1:0] ownAddr;

  assign addrOk  = (nodeAddr >= `COI_NODE_MIN) &&
                   (nodeAddr <= `COI_NODE_MAX);

  // bit 7 of nodeAddr never reaches an id
  assign ownAddr = nodeAddr[`COI_ADDR_MSB:0];

  // ****************************************************************
  // configured identifier table
  // ****************************************************************
  reg [`COI_ID_W-1:0]  cfgTab [0:`COI_SLOTS-1];
  reg [`COI_SLOTS-1:0] ovr_q;
  wire                 cfgSelOk;

  assign cfgSelOk = (cfgSel < `COI_SLOTS);

  // the table itself needs no reset: ovr_q hides stale entries
  always @(posedge clock) begin
    if (cfgMode && cfgWrite && cfgSelOk) begin
      cfgTab[cfgSel] <= cfgId;
    end
  end

  // changes outside the configuration phase are ignored
  always @(posedge clock) begin
    if (rst) begin
      ovr_q <= {`COI_SLOTS{1'b0}};
    end else if (cfgMode && cfgSelOk) begin
      if (cfgWrite) begin
        ovr_q[cfgSel] <= 1'b1;
      end else if (cfgRestore) begin
        ovr_q[cfgSel] <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // slot matchers
  // ****************************************************************
  wire [`COI_ID_W-1:0] effId [0:`COI_SLOTS-1];
  wire [`COI_SLOTS-1:0] slotHit;

  // one matcher per slot
  genvar g;

  generate
    for (g = 0; g < `COI_SLOTS; g = g + 1) begin : gSlot
      coi_id_match #(
        .FC     (slotFc(g)),
        .SHARED ((g == `COI_SLOT_SYNC) ? 1 : 0)
      ) uMatch (
        .nodeAddr (ownAddr),
        .cfgId    (cfgTab[g]),
        .cfgOvr   (ovr_q[g]),
        .rxId     (rxId),
        .effId    (effId[g]),
        .hit      (slotHit[g])
      );
    end
  endgenerate

  // ****************************************************************
  // receive classification
  // ****************************************************************
  reg  [`COI_SLOT_W-1:0] hitSlot;
  reg  [`COI_CLS_W-1:0]  clsD;
  reg  [1:0]             pdoD;
  reg                    ownD;

  wire [`COI_FC_W-1:0]   rxFc;
  wire [`COI_ADDR_W-1:0] rxAddr;
  wire [`COI_FC_W-1:0]   pdoOff;

  integer                i;

  assign rxFc   = rxId[`COI_FC_MSB:`COI_FC_LSB];
  assign rxAddr = rxId[`COI_ADDR_MSB:0];
  assign pdoOff = rxFc - `COI_FC_TPDO1;

  always @* begin
    hitSlot = `COI_SLOT_NONE;
    // lowest receive slot wins if two configured ids collide
    for (i = `COI_SLOTS - 1; i >= 0; i = i - 1) begin
      if (slotHit[i] && slotIsRx(i)) begin
        hitSlot = i[`COI_SLOT_W-1:0];
      end
    end

    clsD = fcClass(rxFc, rxAddr == `COI_ADDR_ZERO);
    pdoD = pdoOff[2:1];
    ownD = 1'b0;

    // NMT and SYNC reach every node
    if (rxId == `COI_ID_NMT) begin
      clsD = `COI_CLS_NMT;
      ownD = 1'b1;
    end else if (hitSlot == `COI_SLOT_SYNC) begin
      clsD = `COI_CLS_SYNC;
      ownD = 1'b1;
    end else if (hitSlot == `COI_SLOT_SDORX) begin
      clsD = `COI_CLS_SDORX;
      ownD = addrOk || ovr_q[`COI_SLOT_SDORX];
    end else if (hitSlot != `COI_SLOT_NONE) begin
      clsD = `COI_CLS_RPDO;
      pdoD = hitSlot[2:1] - 2'h1;
      ownD = addrOk || ovr_q[hitSlot];
    end
  end

  always @(posedge clock) begin
    if (rst) begin
      rxDone     <= 1'b0;
      rxClass    <= `COI_CLS_UNKNOWN;
      rxPdo      <= 2'h0;
      rxSlot     <= `COI_SLOT_NONE;
      rxOwn      <= 1'b0;
      rxOwnCnt   <= {`COI_CNT_W{1'b0}};
      rxOtherCnt <= {`COI_CNT_W{1'b0}};
    end else begin
      rxDone <= rxValid;

      if (rxValid) begin
        rxClass <= clsD;
        rxPdo   <= pdoD;
        rxSlot  <= hitSlot;
        rxOwn   <= ownD;

        // counters wrap; they are diagnostics only
        if (ownD) begin
          rxOwnCnt <= rxOwnCnt + `COI_CNT_ONE;
        end else begin
          rxOtherCnt <= rxOtherCnt + `COI_CNT_ONE;
        end
      end
    end
  end

  // ****************************************************************
  // transmit identifier generation
  // ****************************************************************
  // slots 13..15 answer id 0 and txOk 0
  wire txSelOk;

  assign txSelOk = (txSel < `COI_SLOTS);

  always @(posedge clock) begin
    if (rst) begin
      txDone <= 1'b0;
      txId   <= `COI_ID_NMT;
      txOk   <= 1'b0;
    end else begin
      txDone <= txReq;

      if (txReq) begin
        txId <= txSelOk ? effId[txSel] : `COI_ID_NMT;

        // a default id built from a bad address is not usable
        txOk <= txSelOk && (addrOk || ovr_q[txSel] ||
                            txSel == `COI_SLOT_SYNC);
      end
    end
  end

  // ****************************************************************
  // configuration readback and address flag
  // ****************************************************************
  always @(posedge clock) begin
    if (rst) begin
      cfgRdId  <= `COI_ID_NMT;
      cfgRdOvr <= 1'b0;
      addrBad  <= 1'b0;
    end else begin
      // readback needs no strobe
      cfgRdId  <= cfgSelOk ? effId[cfgSel] : `COI_ID_NMT;
      cfgRdOvr <= cfgSelOk && ovr_q[cfgSel];

      addrBad  <= !addrOk;
    end
  end

  // ****************************************************************
  // dictionary access check
  // ****************************************************************
  wire [`COI_RNG_W-1:0] rangeD;
  wire                  allowD;

  coi_index_class uIndex (
    .index   (dictIndex),
    .access  (dictAccess),
    .isWrite (dictWrite),
    .range   (rangeD),
    .allowed (allowD)
  );

  always @(posedge clock) begin
    if (rst) begin
      dictDone    <= 1'b0;
      dictRange   <= `COI_RNG_RSVD;
      dictAllowed <= 1'b0;
      dictKey     <= {(`COI_IDX_W+`COI_SUB_W){1'b0}};
    end else begin
      dictDone <= dictReq;

      if (dictReq) begin
        dictRange   <= rangeD;
        dictAllowed <= allowD;
        // sub-index only carried, not checked
        dictKey     <= {dictIndex, dictSub};
      end
    end
  end

endmodule

// *** testbench/coi_master_model.sv ***
// network master stand-in that sends frames to the node
`timescale 1ns/1ps
`include "coi_consts.vh"

module coi_master_model (
  input  wire                 clock,   // system clock
  input  wire [3:0]           gap,     // idle cycles between frames
  output reg                  rxValid, // frame strobe
  output reg  [`COI_ID_W-1:0] rxId     // frame identifier
);
  reg [`COI_ID_W-1:0] pend [$];
  reg [3:0]           idleCnt_q;

  initial begin
    rxValid = 1'b0;
    rxId = 11'h2AA;
    idleCnt_q = 4'h0;
  end

  // ********
  // frame queue
  // ********
  task send(input [`COI_FC_W-1:0] fc, input [`COI_ADDR_W-1:0] node);
    pend.push_back({fc, node});
  endtask

  // a quiet bus shows a changing id so a stale one never passes as a frame
  always @(negedge clock) begin
    if (pend.size() != 0 && idleCnt_q == 4'h0) begin
      rxValid <= 1'b1;
      rxId <= pend.pop_front();
      idleCnt_q <= gap;
    end else begin
      rxValid <= 1'b0;
      rxId <= ~rxId;
      if (idleCnt_q != 4'h0)
        idleCnt_q <= idleCnt_q - 4'h1;
    end
  end
endmodule

// *** testbench/coi_classifier_properties.sv ***
// concurrent checks on the identifier classifier ports
`timescale 1ns/1ps
`include "coi_consts.vh"

module coi_classifier_properties (
  input wire                   clock,       // clock
  input wire                   rst,         // reset
  input wire [`COI_NODE_W-1:0] nodeAddr,    // node
  input wire                   rxValid,     // strobe
  input wire [`COI_ID_W-1:0]   rxId,        // id
  input wire                   txReq,       // request
  input wire [`COI_SLOT_W-1:0] txSel,       // slot
  input wire                   dictReq,     // request
  input wire [`COI_IDX_W-1:0]  dictIndex,   // index
  input wire [`COI_SUB_W-1:0]  dictSub,     // sub-index
  input wire [`COI_ACC_W-1:0]  dictAccess,  // attribute
  input wire                   dictWrite,   // write
  input wire                   addrBad,     // flag
  input wire                   rxDone,      // answer
  input wire [`COI_CLS_W-1:0]  rxClass,     // class
  input wire [`COI_SLOT_W-1:0] rxSlot,      // slot
  input wire                   rxOwn,       // ours
  input wire [`COI_CNT_W-1:0]  rxOwnCnt,    // count
  input wire                   txDone,      // answer
  input wire [`COI_ID_W-1:0]   txId,        // id
  input wire                   txOk,        // usable
  input wire                   dictDone,    // answer
  input wire [`COI_RNG_W-1:0]  dictRange,   // range
  input wire                   dictAllowed, // allowed
  input wire [`COI_IDX_W+`COI_SUB_W-1:0] dictKey // key
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  // ********
  // answer shapes
  // ********
  sequence sOwnAns;
    rxDone && rxOwn;
  endsequence
  sequence sTxRefused;
    txDone && txId == 11'h000 && !txOk;
  endsequence

  chk_rx_answer:
    assert property (rxValid |=> rxDone) else $error("rx answer missing");
  chk_rx_hold:
    assert property (!rxValid |=> !rxDone && $stable(rxClass)
      && $stable(rxSlot) && $stable(rxOwn)) else $error("rx answer moved");
  chk_nmt_own:
    assert property (rxValid && rxId == `COI_ID_NMT |=> sOwnAns ##0
      rxClass == `COI_CLS_NMT) else $error("nmt not taken");
  chk_fc_unknown:
    assert property (rxValid && (rxId[`COI_FC_MSB:`COI_FC_LSB] == 4'hD
      || rxId[`COI_FC_MSB:`COI_FC_LSB] == 4'hF) |=> rxDone && !rxOwn
      && rxClass == `COI_CLS_UNKNOWN && rxSlot == `COI_SLOT_NONE)
      else $error("unused code classified");
  chk_own_count:
    assert property (sOwnAns |-> rxOwnCnt == $past(rxOwnCnt) + `COI_CNT_ONE)
      else $error("own count wrong");
  chk_tx_refuse:
    assert property (txReq && txSel > 4'hC |=> sTxRefused)
      else $error("bad slot answered");
  chk_addr_flag:
    assert property (!$past(rst) |-> addrBad == ($past(nodeAddr) <
      `COI_NODE_MIN || $past(nodeAddr) > `COI_NODE_MAX))
      else $error("address flag wrong");
  chk_dict_key:
    assert property (dictReq |=> dictDone
      && dictKey == {$past(dictIndex), $past(dictSub)})
      else $error("dict key wrong");
  chk_dict_write:
    assert property (dictReq |=> dictAllowed == (!$past(dictWrite)
      || $past(dictAccess) == `COI_ACC_RW)) else $error("write permit wrong");
  chk_dict_rsvd:
    assert property (dictReq && (dictIndex == 16'h0000 || dictIndex >
      16'h9FFF || (dictIndex > 16'h025F && dictIndex < 16'h1000))
      |=> dictRange == `COI_RNG_RSVD) else $error("reserved index missed");
endmodule

bind coi_classifier coi_classifier_properties chk (
  .clock, .rst, .nodeAddr, .rxValid, .rxId, .txReq, .txSel, .dictReq,
  .dictIndex, .dictSub, .dictAccess, .dictWrite, .addrBad, .rxDone,
  .rxClass, .rxSlot, .rxOwn, .rxOwnCnt, .txDone, .txId, .txOk, .dictDone,
  .dictRange, .dictAllowed, .dictKey
);

// *** testbench/coi_classifier_tb_top.sv ***
// self-checking bench for the identifier classifier
`timescale 1ns/1ps
`include "coi_consts.vh"

`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin \
  n_fail++; $display("ERROR %s exp %h got %h", nm, ex, got); end end

module coi_classifier_tb_top;
  reg         clock, rst, cfgMode, cfgWrite, cfgRestore;
  reg         txReq, dictReq, dictWrite;
  reg  [7:0]  nodeAddr, dictSub;
  reg  [3:0]  cfgSel, txSel, gap;
  reg  [10:0] cfgId;
  reg  [15:0] dictIndex, expOwn, expOther;
  reg  [1:0]  dictAccess;
  wire        addrBad, cfgRdOvr, rxDone, rxOwn, txDone, txOk;
  wire        dictDone, dictAllowed, rxValid;
  wire [10:0] cfgRdId, txId, rxId;
  wire [3:0]  rxClass, rxSlot;
  wire [1:0]  rxPdo;
  wire [15:0] rxOwnCnt, rxOtherCnt;
  wire [2:0]  dictRange;
  wire [23:0] dictKey;
  integer     n_fail, tests_run, cyc;

  coi_classifier dut (
    .clock, .rst, .nodeAddr, .cfgMode, .cfgWrite, .cfgRestore, .cfgSel,
    .cfgId, .rxValid, .rxId, .txReq, .txSel, .dictReq, .dictIndex, .dictSub,
    .dictAccess, .dictWrite, .addrBad, .cfgRdId, .cfgRdOvr, .rxDone,
    .rxClass, .rxPdo, .rxSlot, .rxOwn, .rxOwnCnt, .rxOtherCnt, .txDone,
    .txId, .txOk, .dictDone, .dictRange, .dictAllowed, .dictKey
  );
  coi_master_model master (.clock, .gap, .rxValid, .rxId);

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // the whole run needs well under a thousand cycles
  always @(posedge clock) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      n_fail = n_fail + 1;
      results;
    end
  end

  // ********
  // tasks
  // ********
  task results;
    begin
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask

  task waitRx;
    integer n;
    begin
      n = 0;
      while (rxDone !== 1'b1 && n < 20) begin
        @(negedge clock);
        n = n + 1;
      end
      `CHK("rxDone", 1'b1, rxDone)
    end
  endtask

  function [3:0] expCls(input [3:0] fc);
    case (fc)
      4'h1: expCls = `COI_CLS_EMCY;
      4'h3, 4'h5, 4'h7, 4'h9: expCls = `COI_CLS_TPDO;
      4'h4, 4'h6, 4'h8, 4'hA: expCls = `COI_CLS_RPDO;
      4'hB: expCls = `COI_CLS_SDOTX;
      4'hC: expCls = `COI_CLS_SDORX;
      4'hE: expCls = `COI_CLS_HBEAT;
      default: expCls = `COI_CLS_UNKNOWN;
    endcase
  endfunction

  task doReset;
    begin
      rst = 1'b1;
      repeat (20) @(negedge clock);
      `CHK("rstRx", {`COI_CLS_UNKNOWN, `COI_SLOT_NONE}, {rxClass, rxSlot})
      `CHK("rstCnt", 32'h0, {rxOwnCnt, rxOtherCnt})
      `CHK("rstOut", 4'h0, {rxDone, txDone, dictDone, cfgRdOvr})
      rst = 1'b0;
      expOwn = 16'h0000;
      expOther = 16'h0000;
      $display("test reset done");
    end
  endtask

  task testRx(input [6:0] node, input [3:0] g);
    integer f, k;
    reg own;
    begin
      nodeAddr = {1'b0, node};
      gap = g;
      repeat (2) @(negedge clock);
      master.send(4'h0, 7'h00);
      master.send(4'h1, 7'h00);
      for (f = 1; f < 16; f = f + 1)
        for (k = 0; k < 2; k = k + 1)
          master.send(f[3:0], node ^ k[6:0]);
      waitRx;
      `CHK("nmt", {1'b1, `COI_CLS_NMT}, {rxOwn, rxClass})
      @(negedge clock);
      waitRx;
      `CHK("sync", 9'h110, {rxOwn, rxClass, rxSlot})
      expOwn = expOwn + 16'h0002;
      for (f = 1; f < 16; f = f + 1)
        for (k = 0; k < 2; k = k + 1) begin
          @(negedge clock);
          waitRx;
          own = k == 0 && (f == 4 || f == 6 || f == 8 || f == 10 || f == 12);
          `CHK("class", expCls(f[3:0]), rxClass)
          `CHK("own", own, rxOwn)
          `CHK("slot", own ? f[3:0] - 4'h1 : `COI_SLOT_NONE, rxSlot)
          if (f >= 3 && f <= 10)
            `CHK("pdo", (f[3:0] - 4'h3) >> 1, {2'b00, rxPdo})
          if (own)
            expOwn = expOwn + 16'h0001;
          else
            expOther = expOther + 16'h0001;
        end
      `CHK("cnt", {expOwn, expOther}, {rxOwnCnt, rxOtherCnt})
      $display("test rx node %0d done", node);
    end
  endtask

  task txAsk(input [3:0] s, input [10:0] eid, input eok);
    begin
      txReq = 1'b1;
      txSel = s;
      @(negedge clock);
      `CHK("txOk", {1'b1, eok}, {txDone, txOk})
      if (eok)
        `CHK("txId", eid, txId)
      txReq = 1'b0;
      @(negedge clock);
    end
  endtask

  task testTx(input [7:0] node);
    integer s;
    reg [3:0] fc;
    reg ok;
    begin
      nodeAddr = node;
      ok = node != 8'h00 && node <= 8'h7F;
      repeat (2) @(negedge clock);
      `CHK("addrBad", !ok, addrBad)
      txAsk(4'h0, 11'h080, 1'b1);
      for (s = 1; s < 14; s = s + 1) begin
        fc = (s == 1) ? 4'h1 : (s == 12) ? 4'hE : s[3:0] + 4'h1;
        txAsk(s[3:0], {fc, 7'h00} + {4'h0, node[6:0]}, ok && s < 13);
      end
      $display("test tx node %0d done", node);
    end
  endtask

  task testDict;
    integer i;
    reg [15:0] ix [0:12];
    reg [2:0] rg [0:12];
    begin
      ix = '{16'h0000, 16'h0001, 16'h025F, 16'h0260, 16'h0FFF, 16'h1000,
             16'h1FFF, 16'h2000, 16'h5FFF, 16'h6000, 16'h9FFF, 16'hA000,
             16'hFFFF};
      rg = '{3'h0, 3'h1, 3'h1, 3'h0, 3'h0, 3'h2, 3'h2, 3'h3, 3'h3, 3'h4,
             3'h4, 3'h0, 3'h0};
      for (i = 0; i < 14; i = i + 1) begin
        if (i >= 1) begin
          `CHK("range", {1'b1, rg[i-1]}, {dictDone, dictRange})
          `CHK("allow", (i % 2) || ((i - 1) % 3 == 1), dictAllowed)
          `CHK("key", {ix[i-1], 8'(i - 1)}, dictKey)
        end
        dictReq = i < 13;
        if (i < 13) begin
          dictIndex = ix[i];
          dictSub = 8'(i);
          dictAccess = 2'(i % 3);
          dictWrite = i % 2;
        end
        @(negedge clock);
      end
      $display("test dict done");
    end
  endtask

  task testCfg;
    begin
      nodeAddr = 8'h05;
      cfgSel = 4'h3;
      cfgId = 11'h222;
      cfgWrite = 1'b1;
      @(negedge clock);
      cfgWrite = 1'b0;
      txAsk(4'h3, 11'h205, 1'b1);
      cfgMode = 1'b1;
      cfgWrite = 1'b1;
      @(negedge clock);
      cfgWrite = 1'b0;
      @(negedge clock);
      `CHK("cfgRd", {1'b1, 11'h222}, {cfgRdOvr, cfgRdId})
      txAsk(4'h3, 11'h222, 1'b1);
      master.send(4'h4, 7'h22);
      master.send(4'h4, 7'h05);
      waitRx;
      `CHK("cfgHit", {1'b1, 4'h3}, {rxOwn, rxSlot})
      @(negedge clock);
      waitRx;
      `CHK("oldId", 1'b0, rxOwn)
      cfgRestore = 1'b1;
      @(negedge clock);
      cfgRestore = 1'b0;
      cfgMode = 1'b0;
      @(negedge clock);
      `CHK("restore", {1'b0, 11'h205}, {cfgRdOvr, cfgRdId})
      $display("test config done");
    end
  endtask

  initial begin
    rst = 1'b1;
    {cfgMode, cfgWrite, cfgRestore, txReq, dictReq, dictWrite} = 6'h00;
    {nodeAddr, dictSub, cfgSel, txSel, gap, cfgId, dictIndex} = '0;
    dictAccess = 2'h0;
    n_fail = 0;
    tests_run = 0;
    cyc = 0;
    doReset;
    testRx(7'h05, 4'h0);
    testRx(7'h7F, 4'h2);
    testTx(8'h01);
    testTx(8'h7F);
    testTx(8'h00);
    testTx(8'h80);
    testDict;
    testCfg;
    doReset;
    results;
  end
endmodule
